//--- hw/sp_serial_port.v
// Serial port with APB registers, async and clocked sync modes and four request lines.
`timescale 1ns/1ps
`include "sp_defines.vh"

module sp_serial_port #(
    parameter DIV_W = 16
) (
    // Clock and reset.
    input  wire        mclk,
    input  wire        rst,
    // APB slave.
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    // Serial line pins.
    input  wire        rxd_in,
    output wire        txd_out,
    output wire        txd_oe,
    input  wire        sclk_in,
    output wire        sclk_out,
    output wire        sclk_oe,
    // Request lines to the interrupt controller.
    output wire        tx_end_irq,
    output wire        rx_error_irq,
    output wire        rx_full_irq,
    output wire        tx_empty_irq,
    output reg  [2:0]  irq_rank
);
    // ==========================================================
    // Declarations
    reg  [7:0]       serial_control_reg;
    reg  [1:0]       port_reg;
    reg  [DIV_W-1:0] divisor;
    reg  [7:0]       tx_data_reg;
    reg  [7:0]       rx_data_reg;
    reg  [7:0]       tx_shift_reg;
    reg  [7:0]       rx_shift_reg;
    reg              tx_buffer_empty_flag;
    reg              tx_complete_flag;
    reg              rx_buffer_full_flag;
    reg              overrun_flag;
    reg              framing_err_flag;
    reg              parity_err_flag;
    reg              rxd_s1, rxd_s2;
    reg              sclk_s1, sclk_s2, sclk_d;
    reg  [3:0]       sclk_ph;
    reg              tx_busy, tx_cont, tx_line;
    reg  [3:0]       tx_idx, tx_cnt;
    reg              rx_busy, rx_par, rx_fin, rx_fe, rx_pe;
    reg  [3:0]       rx_idx, rx_cnt;
    wire             tick;
    wire             tx_irq_enable     = serial_control_reg[`SP_C_TIE];
    wire             rx_irq_enable     = serial_control_reg[`SP_C_RIE];
    wire             tx_enable         = serial_control_reg[`SP_C_TE];
    wire             rx_enable         = serial_control_reg[`SP_C_RE];
    wire             par_en            = serial_control_reg[`SP_C_PAREN];
    wire             tx_end_irq_enable = serial_control_reg[`SP_C_TX_END_IRQ_ENABLE];
    wire             sync_mode         = serial_control_reg[`SP_C_SYNC];
    wire             ext_clk           = serial_control_reg[`SP_C_EXTCLK];
    wire             port_data_bit     = port_reg[`SP_P_DATA];
    wire             port_dir_bit      = port_reg[`SP_P_DIR];
    wire             err_any = overrun_flag | framing_err_flag | parity_err_flag;
    wire [3:0]       stop_idx = par_en ? `SP_STOP_P : `SP_STOP_NP;

    // ==========================================================
    // Address decode, shared by the error answer and the write path.
    function addr_hit;
        input [7:0] a;
        begin
            addr_hit = (a == `SP_OFF_CTRL) || (a == `SP_OFF_STAT) || (a == `SP_OFF_TXD) ||
                       (a == `SP_OFF_RXD) || (a == `SP_OFF_DIV) || (a == `SP_OFF_PORT);
        end
    endfunction

    // Async line level for a frame index: start, data LSB first, even parity, stop.
    function tx_bit_val;
        input [3:0] idx;
        input [7:0] data;
        input       pen;
        reg   [7:0] sh;
        begin
            sh = data >> (idx - 4'h1);
            if (idx == 4'h0)
                tx_bit_val = 1'b0;
            else if (idx <= `SP_SYNC_LAST)
                tx_bit_val = sh[0];
            else if (pen && idx == `SP_PAR_IDX)
                tx_bit_val = ^data;
            else
                tx_bit_val = 1'b1;
        end
    endfunction

    // ==========================================================
    // APB access
    wire acc    = psel & penable;
    wire wr     = acc & pwrite & addr_hit(paddr);
    wire wr_ctl = wr & (paddr == `SP_OFF_CTRL);
    wire wr_st  = wr & (paddr == `SP_OFF_STAT);
    wire wr_tx  = wr & (paddr == `SP_OFF_TXD);
    // Zero wait states: read data is captured during the setup cycle.
    assign pready  = 1'b1;
    assign pslverr = acc & ~addr_hit(paddr);

    // Read data is registered in the setup phase; unmapped reads return zero.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `SP_OFF_CTRL: prdata <= {24'h000000, serial_control_reg};
                `SP_OFF_STAT: prdata <= {24'h000000, tx_buffer_empty_flag, rx_buffer_full_flag,
                                         overrun_flag, framing_err_flag, parity_err_flag,
                                         tx_complete_flag, 2'h0};
                `SP_OFF_TXD:  prdata <= {24'h000000, tx_data_reg};
                `SP_OFF_RXD:  prdata <= {24'h000000, rx_data_reg};
                `SP_OFF_DIV:  prdata <= {{(32-DIV_W){1'b0}}, divisor};
                `SP_OFF_PORT: prdata <= {30'h00000000, port_reg};
                default:      prdata <= 32'h00000000;
            endcase
        end
    end

    // Plain software registers.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            serial_control_reg <= `SP_CTRL_RST;
            port_reg           <= `SP_PORT_RST;
            divisor            <= `SP_DIV_RST;
            tx_data_reg        <= 8'h00;
        end else begin
            if (wr_ctl)
                serial_control_reg <= pwdata[7:0];
            if (wr & (paddr == `SP_OFF_PORT))
                port_reg <= pwdata[1:0];
            if (wr & (paddr == `SP_OFF_DIV))
                divisor <= pwdata[DIV_W-1:0];
            if (wr_tx)
                tx_data_reg <= pwdata[7:0];  // Taken in any flag state; unsent byte is lost.
        end
    end

    // ==========================================================
    // Base clock and pin synchronisers
    sp_baud_gen #(
        .DIV_W   (DIV_W)
    ) u_baud (
        .mclk    (mclk),
        .rst     (rst),
        .divisor (divisor),
        .tick    (tick)
    );

    // Two stages before any logic; sclk_d only delays the second stage for edges.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rxd_s1  <= 1'b1;
            rxd_s2  <= 1'b1;
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_d  <= 1'b1;
        end else begin
            rxd_s1  <= rxd_in;
            rxd_s2  <= rxd_s1;
            sclk_s1 <= sclk_in;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
        end
    end

    // Internal sync clock: low for ticks 0-7, high for 8-15, parked high when idle.
    wire int_run = sync_mode & ~ext_clk & (tx_busy | (rx_enable & ~tx_enable));
    always @(posedge mclk or posedge rst) begin
        if (rst)
            sclk_ph <= `SP_PH_IDLE;
        else if (~int_run)
            sclk_ph <= `SP_PH_IDLE;
        else if (tick)
            sclk_ph <= sclk_ph + 4'h1;
    end
    wire sclk_fall = ext_clk ? (sclk_d & ~sclk_s2) : (int_run & tick & sclk_ph == `SP_PH_FALL);
    wire sclk_rise = ext_clk ? (~sclk_d & sclk_s2) : (int_run & tick & sclk_ph == `SP_PH_RISE);
    assign sclk_out = sclk_ph[3];
    assign sclk_oe  = sync_mode & ~ext_clk;

    // ==========================================================
    // Transmitter
    // Start and continuation both require new data and, in sync mode, no receive error.
    wire can_load  = ~tx_buffer_empty_flag & ~(sync_mode & err_any);
    wire a_end     = tx_busy & ~sync_mode & tick & (tx_cnt == `SP_TICK_LAST);
    wire a_stop    = a_end & ((tx_idx + 4'h1) == stop_idx);
    wire s_end     = tx_busy & sync_mode & sclk_rise & (tx_idx == `SP_SYNC_LAST);
    wire tx_start  = tx_enable & ~tx_busy & can_load;
    wire tx_load   = tx_start | (tx_enable & (a_stop | s_end) & can_load);
    wire tx_done   = tx_enable & (a_stop | s_end) & ~can_load;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_busy      <= 1'b0;
            tx_cont      <= 1'b0;
            tx_line      <= 1'b1;
            tx_idx       <= 4'h0;
            tx_cnt       <= 4'h0;
            tx_shift_reg <= 8'h00;
        end else if (~tx_enable) begin
            // Whatever the state, the transmitter drops back to mark.
            tx_busy <= 1'b0;
            tx_cont <= 1'b0;
            tx_line <= 1'b1;
            tx_idx  <= 4'h0;
            tx_cnt  <= 4'h0;
        end else begin
            if (tx_load)
                tx_shift_reg <= tx_data_reg;
            if (tx_start) begin
                tx_busy <= 1'b1;
                tx_idx  <= 4'h0;
                tx_cnt  <= 4'h0;
                if (~sync_mode)
                    tx_line <= 1'b0;
            end else if (tx_busy & ~sync_mode & tick) begin
                if (tx_cnt != `SP_TICK_LAST) begin
                    tx_cnt <= tx_cnt + 4'h1;
                end else if (tx_idx == stop_idx) begin
                    tx_cnt  <= 4'h0;
                    tx_cont <= 1'b0;
                    tx_idx  <= 4'h0;
                    tx_busy <= tx_cont;
                    tx_line <= ~tx_cont;
                end else begin
                    // Data was checked on entering the stop bit; the stop bit itself goes out unchanged.
                    tx_cnt  <= 4'h0;
                    tx_idx  <= tx_idx + 4'h1;
                    tx_line <= tx_bit_val(tx_idx + 4'h1, tx_shift_reg, par_en);
                    if (a_stop)
                        tx_cont <= can_load;
                end
            end else if (tx_busy & sync_mode) begin
                // Data changes on the falling edge; after the MSB the line holds it.
                if (sclk_fall & (tx_idx != `SP_SYNC_LAST)) begin
                    tx_line <= tx_shift_reg[tx_idx[2:0]];
                    tx_idx  <= tx_idx + 4'h1;
                end else if (s_end) begin
                    tx_idx  <= 4'h0;
                    tx_busy <= can_load;
                end
            end
        end
    end

    // Port data and direction replace the serial function while tx is disabled.
    assign txd_out = tx_enable ? tx_line : port_data_bit;
    assign txd_oe  = tx_enable | port_dir_bit;

    // ==========================================================
    // Receiver
    // A low level at a tick starts a frame, so a break keeps producing frames.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rx_busy      <= 1'b0;
            rx_idx       <= 4'h0;
            rx_cnt       <= 4'h0;
            rx_par       <= 1'b0;
            rx_fin       <= 1'b0;
            rx_fe        <= 1'b0;
            rx_pe        <= 1'b0;
            rx_shift_reg <= 8'h00;
        end else begin
            rx_fin <= 1'b0;
            if (~rx_enable) begin
                // Only the sequencer resets; the flags are kept.
                rx_busy <= 1'b0;
                rx_idx  <= 4'h0;
            end else if (sync_mode) begin
                // Sync mode samples on the rising edge of the serial clock.
                if (sclk_rise) begin
                    rx_shift_reg <= {rxd_s2, rx_shift_reg[7:1]};
                    rx_idx       <= (rx_idx == `SP_RX_LAST) ? 4'h0 : rx_idx + 4'h1;
                    rx_fin       <= (rx_idx == `SP_RX_LAST);
                    rx_fe        <= 1'b0;
                    rx_pe        <= 1'b0;
                end
            end else if (tick) begin
                if (~rx_busy) begin
                    if (~rxd_s2) begin
                        rx_busy <= 1'b1;  // Aligned to the start fall on the base clock.
                        rx_idx  <= 4'h0;
                        rx_cnt  <= 4'h0;
                    end
                end else begin
                    rx_cnt <= rx_cnt + 4'h1;
                    if (rx_cnt == `SP_MID_TICK) begin  // Eighth tick: mid-bit sample.
                        rx_idx <= rx_idx + 4'h1;
                        if (rx_idx == 4'h0) begin
                            rx_busy <= ~rxd_s2;
                            rx_par  <= 1'b0;
                        end else if (rx_idx <= `SP_SYNC_LAST) begin
                            rx_shift_reg <= {rxd_s2, rx_shift_reg[7:1]};
                            rx_par       <= rx_par ^ rxd_s2;
                        end else if (par_en & (rx_idx == `SP_PAR_IDX)) begin
                            rx_par <= rx_par ^ rxd_s2;
                        end else begin
                            // A stop bit at zero, as in a break, is a framing error.
                            rx_busy <= 1'b0;
                            rx_fin  <= 1'b1;
                            rx_fe   <= ~rxd_s2;
                            rx_pe   <= par_en & rx_par;
                        end
                    end
                end
            end
        end
    end

    // ==========================================================
    // Status flags: a hardware set wins over a software write of zero.
    wire clr_tx_buffer_empty_flag = wr_st & ~pwdata[`SP_S_TX_BUFFER_EMPTY_FLAG];
    wire ovr      = rx_fin & rx_buffer_full_flag;
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            tx_buffer_empty_flag <= 1'b1;
            tx_complete_flag     <= 1'b1;
            rx_buffer_full_flag  <= 1'b0;
            overrun_flag         <= 1'b0;
            framing_err_flag     <= 1'b0;
            parity_err_flag      <= 1'b0;
            rx_data_reg          <= 8'h00;
        end else begin
            // Disabled transmitter holds empty at one; a load sets it.
            if (~tx_enable | tx_load)
                tx_buffer_empty_flag <= 1'b1;
            else if (clr_tx_buffer_empty_flag)
                tx_buffer_empty_flag <= 1'b0;
            if (tx_done)
                tx_complete_flag <= 1'b1;
            else if (tx_load | (wr_st & ~pwdata[`SP_S_TX_COMPLETE_FLAG]))
                tx_complete_flag <= 1'b0;
            // Overrun keeps full at one and drops the byte.
            if (ovr)
                overrun_flag <= 1'b1;
            else if (wr_st & ~pwdata[`SP_S_OVERRUN_FLAG])
                overrun_flag <= 1'b0;
            if (rx_fin & rx_fe)
                framing_err_flag <= 1'b1;
            else if (wr_st & ~pwdata[`SP_S_FER])
                framing_err_flag <= 1'b0;
            if (rx_fin & rx_pe)
                parity_err_flag <= 1'b1;
            else if (wr_st & ~pwdata[`SP_S_PER])
                parity_err_flag <= 1'b0;
            // Without overrun the byte is copied; full only sets when error-free.
            if (rx_fin & ~ovr)
                rx_data_reg <= rx_shift_reg;
            if (rx_fin & ~ovr & ~rx_fe & ~rx_pe)
                rx_buffer_full_flag <= 1'b1;
            else if (wr_st & ~pwdata[`SP_S_RX_BUFFER_FULL_FLAG])
                rx_buffer_full_flag <= 1'b0;
        end
    end

    // ==========================================================
    // Request lines: level outputs, flag AND enable.
    assign tx_empty_irq = tx_buffer_empty_flag & tx_irq_enable;
    assign tx_end_irq   = tx_complete_flag & tx_end_irq_enable;
    assign rx_full_irq  = rx_buffer_full_flag & rx_irq_enable;
    assign rx_error_irq = err_any & rx_irq_enable;

    // Highest pending request: 4 rx error, 3 rx full, 2 tx empty, 1 tx end, 0 none.
    always @* begin
        if (rx_error_irq)
            irq_rank = 3'h4;
        else if (rx_full_irq)
            irq_rank = 3'h3;
        else if (tx_empty_irq)
            irq_rank = 3'h2;
        else if (tx_end_irq)
            irq_rank = 3'h1;
        else
            irq_rank = 3'h0;
    end
endmodule

//--- hw/sp_defines.vh
// Register map, field positions, reset values and timing counts of the serial port.
`ifndef SP_DEFINES_VH
`define SP_DEFINES_VH
// ==========================================================
// Register offsets
`define SP_OFF_CTRL   8'h00
`define SP_OFF_STAT   8'h04
`define SP_OFF_TXD    8'h08
`define SP_OFF_RXD    8'h0C
`define SP_OFF_DIV    8'h10
`define SP_OFF_PORT   8'h14
// ==========================================================
// Control register fields
`define SP_C_TIE      7
`define SP_C_RIE      6
`define SP_C_TE       5
`define SP_C_RE       4
`define SP_C_PAREN    3
`define SP_C_TX_END_IRQ_ENABLE     2
`define SP_C_SYNC     1
`define SP_C_EXTCLK   0
// ==========================================================
// Status register fields
`define SP_S_TX_BUFFER_EMPTY_FLAG     7
`define SP_S_RX_BUFFER_FULL_FLAG     6
`define SP_S_OVERRUN_FLAG     5
`define SP_S_FER      4
`define SP_S_PER      3
`define SP_S_TX_COMPLETE_FLAG     2
// ==========================================================
// Port register fields and reset values
`define SP_P_DATA     0
`define SP_P_DIR      1
`define SP_CTRL_RST   8'h00
`define SP_PORT_RST   2'h0
`define SP_DIV_RST    16'h0103
// ==========================================================
// Bit timing in base clock ticks and frame indices
`define SP_TICK_LAST  4'hF
`define SP_MID_TICK   4'h7
`define SP_PH_IDLE    4'hF
`define SP_PH_FALL    4'hF
`define SP_PH_RISE    4'h7
`define SP_SYNC_LAST  4'h8
`define SP_RX_LAST    4'h7
`define SP_STOP_NP    4'h9
`define SP_STOP_P     4'hA
`define SP_PAR_IDX    4'h9
`endif

//--- hw/sp_baud_gen.v
// Base clock generator: one enable pulse per base clock period.
`timescale 1ns/1ps
module sp_baud_gen #(
    parameter DIV_W = 16
) (
    // Clock and reset.
    input  wire             mclk,
    input  wire             rst,
    // Divisor: a tick every divisor+1 cycles of mclk.
    input  wire [DIV_W-1:0] divisor,
    // Base clock enable pulse.
    output reg              tick
);
    reg [DIV_W-1:0] count;

    // ==========================================================
    // Divider
    // Reloading on zero keeps the period exact for any divisor, including zero.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= {DIV_W{1'b0}};
            tick  <= 1'b0;
        end else if (count == {DIV_W{1'b0}}) begin
            count <= divisor;
            tick  <= 1'b1;
        end else begin
            count <= count - {{(DIV_W-1){1'b0}}, 1'b1};
            tick  <= 1'b0;
        end
    end
endmodule

//--- sim/sp_serial_port_checker.sv
// Assertions on the serial port request lines, priority code and pin fallback.
`timescale 1ns/1ps
module sp_checker (
    // Clock, reset and bus.
    input wire        mclk,
    input wire        rst,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pslverr,
    // Pins and requests.
    input wire        txd_out,
    input wire        txd_oe,
    input wire        tx_end_irq,
    input wire        rx_error_irq,
    input wire        rx_full_irq,
    input wire        tx_empty_irq,
    input wire [2:0]  irq_rank
);
    // ==========================================================
    // Helpers
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    wire       acc_wr = psel && penable && pwrite;
    wire       ctl_wr = acc_wr && (paddr == 8'h00);
    reg  [1:0] port_q;
    // Shadow of the port bits, so the pin level after a transmitter reset is known.
    always @(posedge mclk or posedge rst) begin
        if (rst)
            port_q <= 2'h0;
        else if (acc_wr && paddr == 8'h14)
            port_q <= pwdata[1:0];
    end
    // ==========================================================
    // Assertions
    chk_rank_error: assert property (rx_error_irq |-> irq_rank == 3'h4)
        else $error("rank wrong with receive error");
    chk_rank_full: assert property (!rx_error_irq && rx_full_irq |-> irq_rank == 3'h3)
        else $error("rank wrong with receive full");
    chk_rank_empty: assert property (!rx_error_irq && !rx_full_irq && tx_empty_irq |-> irq_rank == 3'h2)
        else $error("rank wrong with transmit empty");
    chk_rank_low: assert property (!rx_error_irq && !rx_full_irq && !tx_empty_irq |-> irq_rank == {2'h0, tx_end_irq})
        else $error("rank wrong with only transmit end");
    chk_tx_gate: assert property (ctl_wr && !pwdata[7] |=> !tx_empty_irq)
        else $error("transmit empty request not gated");
    chk_rx_gate: assert property (ctl_wr && !pwdata[6] |=> !rx_error_irq && !rx_full_irq)
        else $error("receive requests not gated");
    chk_end_gate: assert property (ctl_wr && !pwdata[2] |=> !tx_end_irq)
        else $error("transmit end request not gated");
    chk_port_pin: assert property (ctl_wr && !pwdata[5] |=> txd_out == port_q[0] && txd_oe == port_q[1])
        else $error("pin does not follow port bits");
    chk_full_holds: assert property (rx_full_irq && !acc_wr |=> rx_full_irq)
        else $error("receive full request dropped");
    chk_bad_addr: assert property (psel && penable && paddr > 8'h14 |-> pslverr)
        else $error("no error answer for unmapped address");
endmodule

bind sp_serial_port sp_checker u_chk (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .txd_out, .txd_oe, .tx_end_irq, .rx_error_irq, .rx_full_irq, .tx_empty_irq, .irq_rank);

//--- sim/sp_peer.sv
// Remote serial peer: sends frames on the receive pin and captures transmitted ones.
`timescale 1ns/1ps
module sp_peer #(
    parameter BIT_CYC = 16
) (
    // Clock and lines.
    input wire mclk,
    input wire txd,
    output reg rxd,
    output reg sclk
);
    // ==========================================================
    // Line control
    // The data line and the serial clock both rest high between frames.
    initial rxd = 1'b1;
    initial sclk = 1'b1;
    // Forces a level, used to hold a break.
    task line(input logic v);
        rxd <= v;
    endtask
    // Start bit, eight data bits LSB first, one stop bit, changed just after edges.
    task send(input logic [7:0] d);
        integer i;
        begin
            for (i = 0; i < 10; i = i + 1) begin
                rxd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : d[i-1];
                repeat (BIT_CYC) @(posedge mclk);
            end
        end
    endtask
    // Samples each bit in its middle, so edge jitter of a few cycles is harmless.
    task grab(output logic [7:0] d);
        integer i;
        begin
            @(negedge txd);
            repeat (BIT_CYC / 2) @(posedge mclk);
            for (i = 0; i < 8; i = i + 1) begin
                repeat (BIT_CYC) @(posedge mclk);
                d[i] = txd;
            end
        end
    endtask
    // Eight clock pulses of 200 ns; each bit is taken at the rising edge, where it is settled.
    task pulse8(output logic [7:0] d);
        integer i;
        begin
            repeat (8) @(posedge mclk);  // Well over five cycles after the byte is set up.
            for (i = 0; i < 8; i = i + 1) begin
                sclk <= 1'b0;
                repeat (4) @(posedge mclk);
                sclk <= 1'b1;
                d[i] = txd;
                repeat (4) @(posedge mclk);
            end
        end
    endtask
endmodule

//--- sim/sp_serial_port_bench.sv
// Self-checking bench for the serial port registers, transfers, errors and requests.
`timescale 1ns/1ps
module sp_serial_port_bench;
    // ==========================================================
    // Signals
    logic        mclk, rst, psel, penable, pwrite, rxd_in, pready, pslverr, err;
    logic        txd_out, txd_oe, tx_end_irq, rx_error_irq, rx_full_irq, tx_empty_irq;
    logic        sclk_in, sclk_out, sclk_oe;
    logic [7:0]  paddr, got;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  irq_rank;
    integer      miscompares = 0;
    integer      n_compared = 0;
    // The peer supplies the external sync clock; it stands high outside frames.
    sp_serial_port u_dut (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .rxd_in, .txd_out, .txd_oe, .sclk_in, .sclk_out, .sclk_oe, .tx_end_irq,
        .rx_error_irq, .rx_full_irq, .tx_empty_irq, .irq_rank);
    sp_peer u_peer (.mclk, .txd(txd_out), .rxd(rxd_in), .sclk(sclk_in));
    // Clock at 40 MHz.
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // ==========================================================
    // Tasks
    // One transfer; the request stands until pready is seen at an edge.
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1) @(posedge mclk);
            q = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(q, e);
        end
    endtask
    task conclude;
        begin
            $display("compared %0d, mismatches %0d", n_compared, miscompares);
            if (miscompares == 0 && n_compared > 0)
                $display("Test passed");
            else
                $display("Test failed");
            $finish;
        end
    endtask
    // A hang is cut off well beyond the expected run of about fifteen hundred cycles.
    initial begin
        #(25 * 6000);
        miscompares = miscompares + 1;
        conclude;
    end
    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(8'h04, 32'h84);
        rd(8'h10, 32'h0103);
        rd(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        apb(1'b1, 8'h10, 32'h0);
        // The divider takes the new divisor only once its old count has run out.
        repeat (300) @(posedge mclk);
        apb(1'b1, 8'h14, 32'h3);
        apb(1'b1, 8'h00, 32'hF4);
        chk({tx_empty_irq, tx_end_irq, irq_rank}, 5'h1A);
        apb(1'b1, 8'h08, 32'hA5);
        apb(1'b1, 8'h08, 32'h3C);
        fork
            apb(1'b1, 8'h04, 32'h7F);
            u_peer.grab(got);
        join
        chk(got, 8'h3C);
        repeat (16) @(posedge mclk);
        rd(8'h04, 32'h84);
        u_peer.send(8'h96);
        repeat (8) @(posedge mclk);
        rd(8'h04, 32'hC4);
        chk({rx_full_irq, irq_rank}, 4'hB);
        rd(8'h0C, 32'h96);
        u_peer.send(8'h5A);
        repeat (8) @(posedge mclk);
        rd(8'h04, 32'hE4);
        rd(8'h0C, 32'h96);
        chk({rx_error_irq, irq_rank}, 4'hC);
        apb(1'b1, 8'h04, 32'h87);
        u_peer.line(1'b0);
        repeat (200) @(posedge mclk);
        rd(8'h04, 32'h94);
        rd(8'h0C, 32'h0);
        apb(1'b1, 8'h04, 32'hEF);
        repeat (200) @(posedge mclk);
        rd(8'h04, 32'h94);
        apb(1'b1, 8'h00, 32'hE4);
        u_peer.line(1'b1);
        repeat (40) @(posedge mclk);
        rd(8'h04, 32'h94);
        apb(1'b1, 8'h08, 32'hFF);
        apb(1'b1, 8'h04, 32'h7F);
        repeat (40) @(posedge mclk);
        apb(1'b1, 8'h14, 32'h2);
        chk({31'h0, txd_out}, 32'h1);
        apb(1'b1, 8'h00, 32'h00);
        chk({txd_out, txd_oe, irq_rank}, 5'h08);
        apb(1'b1, 8'h14, 32'h3);
        chk({31'h0, txd_out}, 32'h1);
        // Sync mode on the external clock: a pending framing error holds the byte back.
        apb(1'b1, 8'h00, 32'h23);
        chk({sclk_out, sclk_oe}, 2'h2);
        apb(1'b1, 8'h08, 32'hC3);
        apb(1'b1, 8'h04, 32'h7F);
        rd(8'h04, 32'h10);
        apb(1'b1, 8'h04, 32'hEF);
        u_peer.pulse8(got);
        chk(got, 8'hC3);
        rd(8'h04, 32'h84);
        conclude;
    end
endmodule
